// ### hdl/mtc_consts.vh
// constants for the timer mode and synchronization control block
// assumes byte-wide registers on a plain strobe port, one clock domain
`ifndef MTC_CONSTS_VH
`define MTC_CONSTS_VH
`define MTC_ADDR_W 28
`define MTC_OFF_SYNC 28'h5FFFF01
`define MTC_OFF_MODE 28'h5FFFF02
`define MTC_OFF_FUNC 28'h5FFFF03
`define MTC_OFF_IRQ_STAT 28'h5FFFF40
`define MTC_OFF_IRQ_MASK 28'h5FFFF41
`define MTC_SYNC_MASK 8'h1F
`define MTC_SYNC_FIXED 8'h60
`define MTC_MODE_MASK 8'h7F
`define MTC_MODE_FIXED 8'h00
`define MTC_FUNC_MASK 8'h3F
`define MTC_FUNC_FIXED 8'h40
`define MTC_HI_FIXED 8'h80
`define MTC_RESET_VAL 8'h00
`define MTC_BIT_PHASE 6
`define MTC_BIT_OVERFLOW_FLAG_DIRECTION 5
`define MTC_PWM_LSB 0
`define MTC_PWM_MSB 4
`define MTC_CMB_MSB 5
`define MTC_CMB_LSB 4
`define MTC_BUF_MSB 3
`define MTC_BUF_LSB 0
`define MTC_CMB_COMP 2'h2
`define MTC_CMB_RSYNC 2'h3
`define MTC_IRQ_W 3
`define MTC_IRQ_SYNC 0
`define MTC_IRQ_MODE 1
`define MTC_IRQ_FUNC 2
`endif

// ### hdl/mtc_sync_enable_ch2.v
// two-flop synchroniser for a single level from another domain
// assumes the input may change at any time relative to sys_clk
`timescale 1ns/1ps
module mtc_sync_enable_ch2 (
    sys_clk, // clock
    nrst, // async reset, active low
    clk_en, // clock enable
    d_in, // asynchronous level
    q_out // synchronised level
);
    input wire sys_clk;
    input wire nrst;
    input wire clk_en;
    input wire d_in;
    output wire q_out;
    reg meta_reg;
    reg sync_reg;
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else if (clk_en) begin
            meta_reg <= d_in;
            sync_reg <= meta_reg;
        end
    end
    assign q_out = sync_reg;
endmodule

// ### hdl/mtc_cfg_reg.v
// one byte-wide control register with write mask and fixed read bits
// assumes writes come as single-cycle strobes from the register port
`timescale 1ns/1ps
module mtc_cfg_reg #(
    parameter [7:0] WMASK = 8'hFF,
    parameter [7:0] FIXED = 8'h00,
    parameter [7:0] RVAL = 8'h00
) (
    sys_clk, // clock
    nrst, // async reset, active low
    clk_en, // clock enable
    wr_en, // write this register
    wr_data, // write data
    value, // stored writable bits
    rd_value, // value as seen by a read
    changed // pulse when a write altered the value
);
    input wire sys_clk;
    input wire nrst;
    input wire clk_en;
    input wire wr_en;
    input wire [7:0] wr_data;
    output wire [7:0] value;
    output wire [7:0] rd_value;
    output wire changed;
    reg [7:0] val_reg;
    wire [7:0] val_next;
    assign val_next = wr_data & WMASK;
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            val_reg <= RVAL;
        end else if (clk_en && wr_en) begin
            val_reg <= val_next;
        end
    end
    assign value = val_reg;
    // reserved positions hold their fixed pattern; undetermined bits read as one
    assign rd_value = (val_reg & WMASK) | (FIXED & ~WMASK);
    assign changed = wr_en && (val_next != val_reg);
endmodule

// ### hdl/mtc_top.v
// timer mode and synchronization control: sync, mode and function registers
// assumes a plain strobe register port on sys_clk and a count-clock enable
`timescale 1ns/1ps
`include "mtc_consts.vh"
module mtc_top #(
    parameter NCH = 5
) (
    sys_clk, // 50 MHz clock
    nrst, // async reset, active low
    clk_en, // freezes all state when low
    reg_addr, // register address
    reg_wdata, // write data
    reg_wr, // write strobe
    reg_rd, // read strobe
    reg_rdata, // read data, cycle after the strobe
    count_tick, // count clock edge pulse from the prescaler
    preset_req, // per-channel preset request
    clear_req, // per-channel clear request
    ch2_overflow, // channel 2 counter overflow pulse
    ch2_underflow, // channel 2 counter underflow pulse
    phase_pin_a, // phase input A from a pin
    phase_pin_b, // phase input B from a pin
    sync_enable, // active sync enables per channel
    sync_preset, // per-channel preset strobe
    sync_clear, // per-channel clear strobe
    pulse_mode, // active PWM enables per channel
    phase_count_enable, // channel 2 phase counting
    phase_a_sync, // synchronised phase input A
    phase_b_sync, // synchronised phase input B
    overflow_flag_set, // set pulse for the channel 2 overflow flag
    combine_normal, // channels 3 and 4 separate
    combine_complementary, // complementary PWM on channels 3,4
    combine_reset_sync, // reset-synchronized PWM on channels 3,4
    buffer_enable, // b4, a4, b3, a3 buffer enables
    irq // level interrupt
);
    input wire sys_clk;
    input wire nrst;
    input wire clk_en;
    input wire [`MTC_ADDR_W-1:0] reg_addr;
    input wire [7:0] reg_wdata;
    input wire reg_wr;
    input wire reg_rd;
    output reg [7:0] reg_rdata;
    input wire count_tick;
    input wire [NCH-1:0] preset_req;
    input wire [NCH-1:0] clear_req;
    input wire ch2_overflow;
    input wire ch2_underflow;
    input wire phase_pin_a;
    input wire phase_pin_b;
    output reg [NCH-1:0] sync_enable;
    output reg [NCH-1:0] sync_preset;
    output reg [NCH-1:0] sync_clear;
    output reg [NCH-1:0] pulse_mode;
    output reg phase_count_enable;
    output wire phase_a_sync;
    output wire phase_b_sync;
    output reg overflow_flag_set;
    output reg combine_normal;
    output reg combine_complementary;
    output reg combine_reset_sync;
    output reg [3:0] buffer_enable;
    output wire irq;

    function sel;
        input [`MTC_ADDR_W-1:0] a;
        input [`MTC_ADDR_W-1:0] off;
        begin
            sel = (a == off);
        end
    endfunction

    wire wr_sync;
    wire wr_mode;
    wire wr_func;
    wire wr_stat;
    wire wr_mask;
    assign wr_sync = reg_wr && sel(reg_addr, `MTC_OFF_SYNC);
    assign wr_mode = reg_wr && sel(reg_addr, `MTC_OFF_MODE);
    assign wr_func = reg_wr && sel(reg_addr, `MTC_OFF_FUNC);
    assign wr_stat = reg_wr && sel(reg_addr, `MTC_OFF_IRQ_STAT);
    assign wr_mask = reg_wr && sel(reg_addr, `MTC_OFF_IRQ_MASK);
    wire [7:0] sync_val;
    wire [7:0] sync_rd;
    wire [7:0] mode_val;
    wire [7:0] mode_rd;
    wire [7:0] func_val;
    wire [7:0] func_rd;
    wire sync_chg;
    wire mode_chg;
    wire func_chg;

    // software-visible copies; reserved bits never stored
    mtc_cfg_reg #(
        .WMASK(`MTC_SYNC_MASK),
        .FIXED(`MTC_SYNC_FIXED | `MTC_HI_FIXED),
        .RVAL(`MTC_RESET_VAL)
    ) u_sync (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .clk_en(clk_en),
        .wr_en(wr_sync),
        .wr_data(reg_wdata),
        .value(sync_val),
        .rd_value(sync_rd),
        .changed(sync_chg)
    );
    mtc_cfg_reg #(
        .WMASK(`MTC_MODE_MASK),
        .FIXED(`MTC_MODE_FIXED | `MTC_HI_FIXED),
        .RVAL(`MTC_RESET_VAL)
    ) u_mode (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .clk_en(clk_en),
        .wr_en(wr_mode),
        .wr_data(reg_wdata),
        .value(mode_val),
        .rd_value(mode_rd),
        .changed(mode_chg)
    );
    mtc_cfg_reg #(
        .WMASK(`MTC_FUNC_MASK),
        .FIXED(`MTC_FUNC_FIXED | `MTC_HI_FIXED),
        .RVAL(`MTC_RESET_VAL)
    ) u_func (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .clk_en(clk_en),
        .wr_en(wr_func),
        .wr_data(reg_wdata),
        .value(func_val),
        .rd_value(func_rd),
        .changed(func_chg)
    );

    // phase inputs come from pins, so they pass two flops first
    mtc_sync_enable_ch2 u_pha (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .clk_en(clk_en),
        .d_in(phase_pin_a),
        .q_out(phase_a_sync)
    );
    mtc_sync_enable_ch2 u_phb (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .clk_en(clk_en),
        .d_in(phase_pin_b),
        .q_out(phase_b_sync)
    );

    // an update is pending until the next count clock edge takes it in
    reg pend_reg;
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pend_reg <= 1'b0;
        end else if (clk_en) begin
            if (sync_chg || mode_chg || func_chg) begin
                pend_reg <= 1'b1;
            end else if (count_tick) begin
                pend_reg <= 1'b0;
            end
        end
    end

    wire [1:0] cmb;
    assign cmb = func_val[`MTC_CMB_MSB:`MTC_CMB_LSB];

    // the two combined modes exclude each other and plain operation; 01 acts as 00
    reg cmb_normal_next;
    reg cmb_comp_next;
    reg cmb_rsync_next;
    always @* begin
        cmb_normal_next = 1'b1;
        cmb_comp_next = 1'b0;
        cmb_rsync_next = 1'b0;
        case (cmb)
            `MTC_CMB_COMP: begin
                cmb_normal_next = 1'b0;
                cmb_comp_next = 1'b1;
            end
            `MTC_CMB_RSYNC: begin
                cmb_normal_next = 1'b0;
                cmb_rsync_next = 1'b1;
            end
            default: begin
                cmb_normal_next = 1'b1;
            end
        endcase
    end

    // settings take hold on a count tick only, so a half-written mode set
    // never reaches the counters mid-period
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sync_enable <= {NCH{1'b0}};
            pulse_mode <= {NCH{1'b0}};
            phase_count_enable <= 1'b0;
            combine_normal <= 1'b1;
            combine_complementary <= 1'b0;
            combine_reset_sync <= 1'b0;
            buffer_enable <= 4'h0;
        end else if (clk_en && count_tick) begin
            sync_enable <= sync_val[NCH-1:0];
            pulse_mode <= mode_val[`MTC_PWM_MSB:`MTC_PWM_LSB];
            phase_count_enable <= mode_val[`MTC_BIT_PHASE];
            combine_complementary <= cmb_comp_next;
            combine_reset_sync <= cmb_rsync_next;
            combine_normal <= cmb_normal_next;
            buffer_enable <= func_val[`MTC_BUF_MSB:`MTC_BUF_LSB];
        end
    end

    // a preset or clear in any synchronized channel hits every synchronized one
    wire any_preset;
    wire any_clear;
    assign any_preset = |(preset_req & sync_enable);
    assign any_clear = |(clear_req & sync_enable);
    reg overflow_flag_direction_reg;
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sync_preset <= {NCH{1'b0}};
            sync_clear <= {NCH{1'b0}};
            overflow_flag_set <= 1'b0;
            overflow_flag_direction_reg <= 1'b0;
        end else if (clk_en) begin
            if (count_tick) begin
                overflow_flag_direction_reg <= mode_val[`MTC_BIT_OVERFLOW_FLAG_DIRECTION];
            end
            sync_preset <= preset_req | ({NCH{any_preset}} & sync_enable);
            sync_clear <= clear_req | ({NCH{any_clear}} & sync_enable);
            overflow_flag_set <= ch2_overflow || (!overflow_flag_direction_reg && ch2_underflow);
        end
    end

    // interrupt: a write to any control register that changed its value
    reg [`MTC_IRQ_W-1:0] stat_reg;
    reg [`MTC_IRQ_W-1:0] mask_reg;
    wire [`MTC_IRQ_W-1:0] ev;
    wire [`MTC_IRQ_W-1:0] clr;
    assign ev = {func_chg, mode_chg, sync_chg};
    assign clr = wr_stat ? reg_wdata[`MTC_IRQ_W-1:0] : {`MTC_IRQ_W{1'b0}};
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            stat_reg <= {`MTC_IRQ_W{1'b0}};
            mask_reg <= {`MTC_IRQ_W{1'b0}};
        end else if (clk_en) begin
            // a new event wins over a simultaneous clear
            stat_reg <= (stat_reg & ~clr) | ev;
            if (wr_mask) begin
                mask_reg <= reg_wdata[`MTC_IRQ_W-1:0];
            end
        end
    end
    assign irq = |(stat_reg & mask_reg);

    // unmapped addresses read zero, so software probing the gap sees no ghost
    reg [7:0] rd_mux;
    always @* begin
        rd_mux = 8'h00;
        case (reg_addr)
            `MTC_OFF_SYNC: begin
                rd_mux = sync_rd;
            end
            `MTC_OFF_MODE: begin
                rd_mux = mode_rd;
            end
            `MTC_OFF_FUNC: begin
                rd_mux = func_rd;
            end
            `MTC_OFF_IRQ_STAT: begin
                rd_mux = {5'h00, stat_reg};
            end
            `MTC_OFF_IRQ_MASK: begin
                rd_mux = {5'h00, mask_reg};
            end
            default: begin
                rd_mux = 8'h00;
            end
        endcase
    end

    // read data stand only in the cycle after the strobe
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
        end else if (clk_en) begin
            if (reg_rd) begin
                reg_rdata <= rd_mux;
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end
endmodule

// ### verification/mtc_assertions.sv
// checker for the timer mode and synchronization control block
// assumes one clock domain, sees only the ports of mtc_top
`timescale 1ns/1ps
`include "mtc_consts.vh"
module mtc_assertions #(
    parameter NCH = 5
) (
    input wire sys_clk,
    input wire nrst,
    input wire clk_en,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire count_tick,
    input wire [NCH-1:0] preset_req,
    input wire [NCH-1:0] clear_req,
    input wire ch2_overflow,
    input wire ch2_underflow,
    input wire phase_pin_a,
    input wire [NCH-1:0] sync_enable,
    input wire [NCH-1:0] sync_preset,
    input wire [NCH-1:0] sync_clear,
    input wire [NCH-1:0] pulse_mode,
    input wire phase_count_enable,
    input wire phase_a_sync,
    input wire overflow_flag_set,
    input wire combine_normal,
    input wire combine_complementary,
    input wire combine_reset_sync,
    input wire [3:0] buffer_enable
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    chk_preset_join: assert property (clk_en && |(preset_req & sync_enable) |=>
        (sync_preset & $past(sync_enable)) == $past(sync_enable)) else $error("preset not joined");
    chk_clear_join: assert property (clk_en && |(clear_req & sync_enable) |=>
        (sync_clear & $past(sync_enable)) == $past(sync_enable)) else $error("clear not joined");
    chk_strobe_idle: assert property (clk_en && !(|preset_req) && !(|clear_req) |=>
        !(|sync_preset) && !(|sync_clear)) else $error("strobe without request");
    chk_ovf_flag: assert property (clk_en && ch2_overflow |=> overflow_flag_set)
        else $error("overflow did not set flag");
    chk_flag_cause: assert property (clk_en && !ch2_overflow && !ch2_underflow |=>
        !overflow_flag_set) else $error("flag set without event");
    chk_combine_onehot: assert property ($onehot({combine_normal,
        combine_complementary, combine_reset_sync})) else $error("combine state not onehot");
    chk_mode_on_tick: assert property ($changed({pulse_mode, phase_count_enable,
        combine_normal, combine_complementary, combine_reset_sync, buffer_enable}) |->
        $past(count_tick) && $past(clk_en)) else $error("mode changed off count tick");
    chk_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read cycle");
    chk_phase_delay: assert property ($past(nrst, 2) && $past(clk_en) && $past(clk_en, 2)
        |-> phase_a_sync == $past(phase_pin_a, 2)) else $error("phase input delay wrong");
    chk_reset_modes: assert property ($rose(nrst) |-> combine_normal && !(|pulse_mode)
        && !(|buffer_enable) && !(|sync_enable)) else $error("mode outputs not reset");
    cover property (clk_en && |(preset_req & sync_enable));
    cover property (combine_complementary);
    cover property (overflow_flag_set && !$past(ch2_overflow));
endmodule
bind mtc_top mtc_assertions #(.NCH(NCH)) u_chk (.*);

// ### verification/mtc_top_tb.sv
// self-checking bench for the timer mode and synchronization control block
// assumes the strobe register port and registered pulse outputs of mtc_top
`timescale 1ns/1ps
`include "mtc_consts.vh"
module mtc_top_tb;
    logic sys_clk = '0, nrst = '0, clk_en = 1'h1, reg_wr = '0, reg_rd = '0, count_tick = '0;
    logic ch2_overflow = '0, ch2_underflow = '0, phase_pin_a = '0, phase_pin_b = '0;
    logic [`MTC_ADDR_W-1:0] reg_addr = '0;
    logic [7:0] reg_wdata = '0;
    logic [4:0] preset_req = '0, clear_req = '0;
    wire [7:0] reg_rdata;
    wire [4:0] sync_enable, sync_preset, sync_clear, pulse_mode;
    wire [3:0] buffer_enable;
    wire phase_count_enable, phase_a_sync, phase_b_sync, overflow_flag_set;
    wire combine_normal, combine_complementary, combine_reset_sync, irq;
    int num_errors = 0, total_checks = 0;
    mtc_top #(.NCH(5)) uut (.*);
    initial begin
        forever #10 sys_clk = ~sys_clk;
    end
    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(logic [27:0] a, logic [7:0] d);
        @(posedge sys_clk);
        {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'h1};
        @(posedge sys_clk);
        reg_wr <= 1'h0;
        #1;
    endtask
    task automatic rd(logic [27:0] a, logic [7:0] exp, string what);
        @(posedge sys_clk);
        {reg_addr, reg_rd} <= {a, 1'h1};
        @(posedge sys_clk);
        reg_rd <= 1'h0;
        #1;
        chk(what, exp, reg_rdata);
    endtask
    // one-cycle event pulses; outputs are judged one settle step after the taking edge
    task automatic pulse(logic [4:0] p, logic [4:0] c, logic o, logic u, logic t);
        @(posedge sys_clk);
        {preset_req, clear_req, ch2_overflow, ch2_underflow, count_tick} <= {p, c, o, u, t};
        @(posedge sys_clk);
        {preset_req, clear_req, ch2_overflow, ch2_underflow, count_tick} <= '0;
        #1;
    endtask
    task automatic t_reset;
        rd(`MTC_OFF_SYNC, 8'hE0, "sync reset");
        rd(`MTC_OFF_MODE, 8'h80, "mode reset");
        rd(`MTC_OFF_FUNC, 8'hC0, "func reset");
        chk("combine reset", 8'h04, {5'h0, combine_normal, combine_complementary,
            combine_reset_sync});
        @(posedge sys_clk);
        phase_pin_a <= 1'h1;
        repeat (3) @(posedge sys_clk);
        #1;
        chk("phase a", 8'h01, {7'h0, phase_a_sync});
    endtask
    task automatic t_reserved;
        logic [27:0] a [3] = '{`MTC_OFF_SYNC, `MTC_OFF_MODE, `MTC_OFF_FUNC};
        logic [7:0] f [3] = '{8'hE0, 8'h80, 8'hC0};
        for (int i = 0; i < 3; i++) begin
            wr(a[i], 8'hFF);
            rd(a[i], 8'hFF, "all ones");
            wr(a[i], 8'h00);
            rd(a[i], f[i], "fixed bits");
        end
        rd(28'h5FFFF3F, 8'h00, "unmapped");
        chk("no tick hold", 8'h00, {3'h0, pulse_mode});
    endtask
    task automatic t_mode;
        for (int i = 0; i < 5; i++) begin
            wr(`MTC_OFF_MODE, 8'h40 | (8'h01 << i));
            chk("pwm early", i ? 8'h01 << (i - 1) : 8'h00, {3'h0, pulse_mode});
            pulse('0, '0, 1'h0, 1'h0, 1'h1);
            chk("pwm", 8'h01 << i, {3'h0, pulse_mode});
            chk("phase mode", 8'h01, {7'h0, phase_count_enable});
        end
        wr(`MTC_OFF_MODE, 8'h20);
        pulse('0, '0, 1'h0, 1'h0, 1'h1);
        chk("phase off", 8'h00, {7'h0, phase_count_enable});
        pulse('0, '0, 1'h0, 1'h1, 1'h0);
        chk("underflow ignored", 8'h00, {7'h0, overflow_flag_set});
        pulse('0, '0, 1'h1, 1'h0, 1'h0);
        chk("overflow", 8'h01, {7'h0, overflow_flag_set});
        wr(`MTC_OFF_MODE, 8'h00);
        pulse('0, '0, 1'h0, 1'h0, 1'h1);
        pulse('0, '0, 1'h0, 1'h1, 1'h0);
        chk("underflow", 8'h01, {7'h0, overflow_flag_set});
    endtask
    task automatic t_func;
        logic [2:0] e [4] = '{3'h4, 3'h4, 3'h2, 3'h1};
        for (int i = 0; i < 4; i++) begin
            wr(`MTC_OFF_FUNC, 8'(i << 4));
            pulse('0, '0, 1'h0, 1'h0, 1'h1);
            chk("combine", {5'h0, e[i]}, {5'h0, combine_normal, combine_complementary,
                combine_reset_sync});
        end
        for (int i = 0; i < 4; i++) begin
            wr(`MTC_OFF_FUNC, 8'h01 << i);
            pulse('0, '0, 1'h0, 1'h0, 1'h1);
            chk("buffer", 8'h01 << i, {4'h0, buffer_enable});
        end
    endtask
    task automatic t_sync;
        wr(`MTC_OFF_SYNC, 8'h03);
        pulse('0, '0, 1'h0, 1'h0, 1'h1);
        chk("sync enable", 8'h03, {3'h0, sync_enable});
        pulse(5'h02, '0, 1'h0, 1'h0, 1'h0);
        chk("joined preset", 8'h03, {3'h0, sync_preset});
        pulse(5'h10, '0, 1'h0, 1'h0, 1'h0);
        chk("lone preset", 8'h00, {4'h0, sync_preset[3:0]});
        pulse('0, 5'h01, 1'h0, 1'h0, 1'h0);
        chk("joined clear", 8'h03, {3'h0, sync_clear});
    endtask
    // mode change events feed the sticky status, so mask before provoking one
    task automatic t_irq;
        wr(`MTC_OFF_IRQ_MASK, 8'h00);
        wr(`MTC_OFF_IRQ_STAT, 8'h07);
        wr(`MTC_OFF_MODE, 8'h01);
        chk("irq masked", 8'h00, {7'h0, irq});
        wr(`MTC_OFF_IRQ_MASK, 8'h02);
        chk("irq raised", 8'h01, {7'h0, irq});
        wr(`MTC_OFF_IRQ_STAT, 8'h02);
        chk("irq cleared", 8'h00, {7'h0, irq});
    endtask
    // a low enable must hold every register, the pin synchronisers included
    task automatic t_freeze;
        wr(`MTC_OFF_MODE, 8'h04);
        @(posedge sys_clk);
        {clk_en, phase_pin_b} <= 2'h1;
        pulse('0, '0, 1'h0, 1'h0, 1'h1);
        repeat (2) @(posedge sys_clk);
        #1;
        chk("frozen pwm", 8'h00, {3'h0, pulse_mode});
        chk("frozen phase b", 8'h00, {7'h0, phase_b_sync});
        @(posedge sys_clk);
        clk_en <= 1'h1;
        pulse('0, '0, 1'h0, 1'h0, 1'h1);
        chk("thawed pwm", 8'h04, {3'h0, pulse_mode});
        repeat (2) @(posedge sys_clk);
        #1;
        chk("phase b", 8'h01, {7'h0, phase_b_sync});
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge sys_clk);
        nrst <= 1'h1;
        t_reset();
        t_reserved();
        t_mode();
        t_func();
        t_sync();
        t_irq();
        t_freeze();
        test_done();
    end
    initial begin
        repeat (3000) @(posedge sys_clk);
        num_errors++;
        test_done();
    end
endmodule
